// file: include/pess_pkg.sv
// Constants shared by the particle energy step sequencer.
`default_nettype none

package pess_pkg;

    // ----------------------------------------------------------------
    // Clock and timing
    // ----------------------------------------------------------------
    localparam int CLK_HZ = 100_000_000;
    localparam int TICK_MS = 250;
    localparam int TICK_CYC = CLK_HZ / 1000 * TICK_MS;
    localparam int DEAD_NS = 3500;
    localparam int DEAD_CYC = (DEAD_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
    // Angles are kept in tenths of a degree.
    localparam int ROT_SPAN_DD = 2200;
    localparam int ROT_RATE_DD = 14;
    localparam int STEP_CYC = CLK_HZ / ROT_RATE_DD;
    localparam int FILT_HZ = 3000;
    localparam int FILT_SH = $clog2(CLK_HZ / (6 * FILT_HZ));
    localparam int NLEVEL = 64;
    localparam int NACC = 6;
    localparam int NDET = 5;
    localparam int NROT = 4;
    localparam logic [11:0] ROT_MAX = 12'h898;

    // ----------------------------------------------------------------
    // Register offsets
    // ----------------------------------------------------------------
    localparam logic [7:0] OFS_CTRL = 8'h00;
    localparam logic [7:0] OFS_DWCFG = 8'h04;
    localparam logic [7:0] OFS_DUR = 8'h08;
    localparam logic [7:0] OFS_LIM = 8'h0c;
    localparam logic [7:0] OFS_PARK = 8'h10;
    localparam logic [7:0] OFS_STAT = 8'h14;
    localparam logic [7:0] OFS_EWPOS = 8'h18;
    localparam logic [7:0] OFS_FILT = 8'h1c;
    localparam logic [7:0] OFS_ACC0 = 8'h20;

    // ----------------------------------------------------------------
    // Field positions and reset values
    // ----------------------------------------------------------------
    localparam int CTRL_DWELL_B = 0;
    localparam int CTRL_HV_B = 1;
    localparam int CTRL_EWHOLD_B = 2;
    localparam int CTRL_FILT_B = 3;
    localparam int CTRL_FSRC_LSB = 4;
    localparam int CTRL_GANG_B = 7;
    localparam int CTRL_GSRC_LSB = 8;
    localparam int CTRL_PARK_B = 11;
    localparam int DW_SPACE_LSB = 8;
    localparam int DW_COUNT_LSB = 16;
    localparam int LIM_HI_LSB = 12;
    localparam logic [31:0] CTRL_RST = 32'h0000_0000;
    localparam logic [31:0] DWCFG_RST = 32'h0001_0100;
    localparam logic [31:0] DUR_RST = 32'h0000_0004;
    localparam logic [31:0] LIM_RST = 32'h0089_8000;
    localparam logic [31:0] PARK_RST = 32'h0000_0000;

endpackage

`default_nettype wire

// file: verilog/pess_core.sv
// Energy stepping, accumulation, rotation and rate filter control.
// Functional notes
// - Scan steps 64 levels, lowest to highest.
// - Each level held 250 ms.
// - After level 64, scan restarts at lowest.
// - Scan-dwell: one scan, then dwell at first level.
// - After dwell, scan again, next dwell adds spacing.
// - After dwell count reached, program restarts.
// - Dwell parameters loaded by ground command.
// - Six accumulators, one reading per 0.25 s.
// - Rotating detectors one each, fixed detector two.
// - Ganging in a dwell gives one detector 24 readings/s.
// - Rotation span limited to 220 degrees.
// - Assemblies step at about 1.4 deg/s.
// - Rotation can halt at preselected position.
// - End limits commandable for small oscillation.
// - Synchronous rotation or east-west held fixed.
// - 3 kHz rate filter on selected detector; the shift sets the cutoff near 1.9 kHz.
// - Dead time after each counted pulse.
// - Bias high voltage selects one of two.
// - Suppressor negative above selection point.
// - Power-up gives scan-only, full-range rotation.
`timescale 1ns/1ns
`default_nettype none

module pess_core #(
    parameter int TICK_CYC = pess_pkg::TICK_CYC,
    parameter int STEP_CYC = pess_pkg::STEP_CYC,
    parameter int DEAD_CYC = pess_pkg::DEAD_CYC,
    parameter logic [5:0] SUPP_LEVEL = 6'h20
) (
    input wire logic core_clk,
    input wire logic rstn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic pready,
    output logic [31:0] prdata,
    output logic pslverr,
    input wire logic [4:0] detPulse,
    output logic [5:0] energyLevel,
    output logic suppNeg,
    output logic hvHigh,
    output wire logic [1:0] stepPulse,
    output wire logic [1:0] stepDir,
    output logic [15:0] filtOut
);

    // ----------------------------------------------------------------
    // Parameter checks
    // ----------------------------------------------------------------
    if (TICK_CYC < 12 || STEP_CYC < 2 || DEAD_CYC < 1 || DEAD_CYC > 511) begin : g_chk
        $error("pess_core: timing parameter out of range");
    end

    typedef enum logic {PESS_SCAN, PESS_DWELL} pess_phase_e;
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rstn);

    // Accumulator k counts detector p under normal or ganged routing.
    function automatic logic accHit(input int k, input logic [4:0] p,
        input logic g, input logic [2:0] gs, input logic [2:0] sl);
        if (g) begin
            return (gs < 3'h5) && p[gs] && (sl == 3'(k));
        end
        return p[(k < pess_pkg::NROT) ? k : pess_pkg::NROT];
    endfunction

    // ----------------------------------------------------------------
    // Register bus
    // ----------------------------------------------------------------
    logic [31:0] ctrl_q, dwCfg_q, dur_q, lim_q, park_q;
    logic [31:0] rdMux;
    logic [15:0] accRd [pess_pkg::NACC];
    logic [11:0] nsPos, ewPos;
    logic setupAcc, doWrite, hit, accArea;
    pess_phase_e phase_q;
    logic [5:0] level_q;
    logic [7:0] dwellIdx_q;
    logic [23:0] filtY_q;

    assign setupAcc = psel && penable && !pready;
    assign doWrite = psel && penable && pready && pwrite;
    assign accArea = (paddr[7:5] == 3'h1) && (paddr[4:2] < 3'h6) && (paddr[1:0] == 2'h0);
    assign hit = accArea || (paddr[7:5] == 3'h0 && paddr[1:0] == 2'h0);

    // Read selection; reserved bits read as zero.
    always_comb begin
        rdMux = 32'h0000_0000;
        unique case (paddr)
            pess_pkg::OFS_CTRL: rdMux = ctrl_q;
            pess_pkg::OFS_DWCFG: rdMux = dwCfg_q;
            pess_pkg::OFS_DUR: rdMux = dur_q;
            pess_pkg::OFS_LIM: rdMux = lim_q;
            pess_pkg::OFS_PARK: rdMux = park_q;
            pess_pkg::OFS_STAT: rdMux = {4'h0, nsPos, dwellIdx_q, suppNeg, phase_q == PESS_DWELL,
                level_q};
            pess_pkg::OFS_EWPOS: rdMux = {20'h00000, ewPos};
            pess_pkg::OFS_FILT: rdMux = {16'h0000, filtOut};
            default: rdMux = accArea ? {16'h0000, accRd[paddr[4:2]]} : 32'h0000_0000;
        endcase
    end

    // One wait state: pready rises in the second access cycle, and a write
    // lands on the same edge at which the master sees pready.
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            pready <= 1'b0;
            prdata <= 32'h0000_0000;
            pslverr <= 1'b0;
        end else begin
            pready <= setupAcc;
            prdata <= setupAcc ? rdMux : 32'h0000_0000;
            pslverr <= setupAcc && !hit;
        end
    end

    // Command registers; reset values give scan-only, full range.
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            ctrl_q <= pess_pkg::CTRL_RST;
            dwCfg_q <= pess_pkg::DWCFG_RST;
            dur_q <= pess_pkg::DUR_RST;
            lim_q <= pess_pkg::LIM_RST;
            park_q <= pess_pkg::PARK_RST;
        end else if (doWrite) begin
            if (paddr == pess_pkg::OFS_CTRL) ctrl_q <= {20'h00000, pwdata[11:0]};
            if (paddr == pess_pkg::OFS_DWCFG) dwCfg_q <= {8'h00, pwdata[23:0]};
            if (paddr == pess_pkg::OFS_DUR) dur_q <= {16'h0000, pwdata[15:0]};
            if (paddr == pess_pkg::OFS_LIM) lim_q <= {8'h00, pwdata[23:0]};
            if (paddr == pess_pkg::OFS_PARK) park_q <= {20'h00000, pwdata[11:0]};
        end
    end

    assign hvHigh = ctrl_q[pess_pkg::CTRL_HV_B];

    // ----------------------------------------------------------------
    // Energy program
    // ----------------------------------------------------------------
    logic [31:0] tickCnt_q, slotCnt_q;
    logic [2:0] slot_q;
    logic [5:0] dwellLvl_q, nextDwell;
    logic [16:0] dwellTick_q;
    logic tick, slotEnd, scanEnd, dwellEnd, lastDwell, dwellMode;

    assign tick = tickCnt_q == 32'(TICK_CYC - 1);
    assign slotEnd = slotCnt_q == 32'(TICK_CYC / pess_pkg::NACC - 1);
    assign dwellMode = ctrl_q[pess_pkg::CTRL_DWELL_B];
    assign scanEnd = tick && phase_q == PESS_SCAN && level_q == 6'h3f;
    assign dwellEnd = tick && phase_q == PESS_DWELL &&
        (!dwellMode || dwellTick_q + 17'h00001 >= {1'b0, dur_q[15:0]});
    assign lastDwell = dwellIdx_q + 8'h01 >= dwCfg_q[pess_pkg::DW_COUNT_LSB +: 8];
    // The sum is taken in six bits so a dwell past the top wraps.
    assign nextDwell = (dwellIdx_q == 8'h00) ? dwCfg_q[5:0] :
        dwellLvl_q + dwCfg_q[pess_pkg::DW_SPACE_LSB +: 6];

    // Quarter-second tick and the six sub-slots used when ganged.
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            tickCnt_q <= 32'h0000_0000;
            slotCnt_q <= 32'h0000_0000;
            slot_q <= 3'h0;
        end else begin
            tickCnt_q <= tick ? 32'h0000_0000 : tickCnt_q + 32'h0000_0001;
            slotCnt_q <= (tick || slotEnd) ? 32'h0000_0000 : slotCnt_q + 32'h0000_0001;
            slot_q <= tick ? 3'h0 : (slotEnd && slot_q < 3'h5) ? slot_q + 3'h1 : slot_q;
        end
    end

    // Scan and dwell sequencing.
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            phase_q <= PESS_SCAN;
            level_q <= 6'h00;
            dwellLvl_q <= 6'h00;
            dwellIdx_q <= 8'h00;
            dwellTick_q <= 17'h00000;
        end else if (scanEnd && dwellMode) begin
            phase_q <= PESS_DWELL;
            level_q <= nextDwell;
            dwellLvl_q <= nextDwell;
            dwellTick_q <= 17'h00000;
        end else if (scanEnd) begin
            level_q <= 6'h00;
        end else if (dwellEnd) begin
            phase_q <= PESS_SCAN;
            level_q <= 6'h00;
            dwellIdx_q <= lastDwell ? 8'h00 : dwellIdx_q + 8'h01;
        end else if (tick && phase_q == PESS_SCAN) begin
            level_q <= level_q + 6'h01;
        end else if (tick) begin
            dwellTick_q <= dwellTick_q + 17'h00001;
        end
    end

    assign energyLevel = level_q;

    // Suppressor follows the selected step one cycle later.
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            suppNeg <= 1'b0;
        end else begin
            suppNeg <= level_q >= SUPP_LEVEL;
        end
    end

    // ----------------------------------------------------------------
    // Detector pulses
    // ----------------------------------------------------------------
    logic [4:0] detS1_q, detS2_q, detS3_q, counted;

    // Pulses are asynchronous; the edge is taken after two flops.
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            detS1_q <= 5'h00;
            detS2_q <= 5'h00;
            detS3_q <= 5'h00;
        end else begin
            detS1_q <= detPulse;
            detS2_q <= detS1_q;
            detS3_q <= detS2_q;
        end
    end

    for (genvar d = 0; d < pess_pkg::NDET; d++) begin : g_det
        logic [8:0] dead_q, gap_q;
        assign counted[d] = detS2_q[d] && !detS3_q[d] && dead_q == 9'h000;
        // Edges inside the dead window are after-pulses and are dropped.
        always_ff @(posedge core_clk or negedge rstn) begin
            if (!rstn) begin
                dead_q <= 9'h000;
            end else if (counted[d]) begin
                dead_q <= 9'(DEAD_CYC - 1);
            end else if (dead_q != 9'h000) begin
                dead_q <= dead_q - 9'h001;
            end
        end
        // Cycles since the last count, saturating; only the check reads it.
        always_ff @(posedge core_clk or negedge rstn) begin
            if (!rstn) begin
                gap_q <= 9'h1ff;
            end else begin
                gap_q <= counted[d] ? 9'h000 : gap_q + 9'(gap_q != 9'h1ff);
            end
        end
        deadTime_a: assert property (counted[d] |-> gap_q >= 9'(DEAD_CYC - 1))
            else $error("pulse counted inside dead time");
    end

    // ----------------------------------------------------------------
    // Accumulators
    // ----------------------------------------------------------------
    logic gangOn;
    // Ganging only applies in a dwell, where the level is steady.
    assign gangOn = ctrl_q[pess_pkg::CTRL_GANG_B] && phase_q == PESS_DWELL;

    for (genvar k = 0; k < pess_pkg::NACC; k++) begin : g_acc
        logic [15:0] acc_q, rd_q;
        logic inc;
        assign inc = accHit(k, counted, gangOn, ctrl_q[pess_pkg::CTRL_GSRC_LSB +: 3],
            slot_q);
        assign accRd[k] = rd_q;
        // Counts saturate rather than wrap, so a hot channel reads full.
        always_ff @(posedge core_clk or negedge rstn) begin
            if (!rstn) begin
                acc_q <= 16'h0000;
                rd_q <= 16'h0000;
            end else if (tick) begin
                rd_q <= acc_q;
                acc_q <= {15'h0000, inc};
            end else if (inc && acc_q != 16'hffff) begin
                acc_q <= acc_q + 16'h0001;
            end
        end
    end

    // ----------------------------------------------------------------
    // Assembly rotation
    // ----------------------------------------------------------------
    logic [31:0] stepCnt_q;
    logic stepTick;
    logic [11:0] loLim, limHi, hiLim, parkPos;

    assign stepTick = stepCnt_q == 32'(STEP_CYC - 1);
    assign loLim = lim_q[11:0];
    assign limHi = lim_q[pess_pkg::LIM_HI_LSB +: 12];
    assign hiLim = (limHi > pess_pkg::ROT_MAX) ? pess_pkg::ROT_MAX : limHi;
    assign parkPos = (park_q[11:0] > pess_pkg::ROT_MAX) ? pess_pkg::ROT_MAX : park_q[11:0];

    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            stepCnt_q <= 32'h0000_0000;
        end else begin
            stepCnt_q <= stepTick ? 32'h0000_0000 : stepCnt_q + 32'h0000_0001;
        end
    end

    for (genvar a = 0; a < 2; a++) begin : g_rot
        logic [11:0] pos_q, pos_d;
        logic dir_q, dir_d, pulse_q, pulse_d, held;
        assign held = (a == 1) && ctrl_q[pess_pkg::CTRL_EWHOLD_B];
        assign stepPulse[a] = pulse_q;
        assign stepDir[a] = dir_q;
        // Sweep between limits, or walk to the park angle and stay.
        always_comb begin
            pos_d = pos_q;
            dir_d = dir_q;
            pulse_d = 1'b0;
            if (stepTick && !held) begin
                if (ctrl_q[pess_pkg::CTRL_PARK_B]) begin
                    if (pos_q != parkPos) begin
                        dir_d = pos_q < parkPos;
                        pos_d = (pos_q < parkPos) ? pos_q + 12'h001 : pos_q - 12'h001;
                        pulse_d = 1'b1;
                    end
                end else if (dir_q && pos_q < hiLim) begin
                    pos_d = pos_q + 12'h001;
                    pulse_d = 1'b1;
                end else if (!dir_q && pos_q > loLim) begin
                    pos_d = pos_q - 12'h001;
                    pulse_d = 1'b1;
                end else begin
                    dir_d = !dir_q;
                end
            end
        end
        always_ff @(posedge core_clk or negedge rstn) begin
            if (!rstn) begin
                pos_q <= 12'h000;
                dir_q <= 1'b1;
                pulse_q <= 1'b0;
            end else begin
                pos_q <= pos_d;
                dir_q <= dir_d;
                pulse_q <= pulse_d;
            end
        end
        rotSpan_a: assert property (pos_q <= pess_pkg::ROT_MAX)
            else $error("assembly beyond rotation span");
    end

    assign nsPos = g_rot[0].pos_q;
    assign ewPos = g_rot[1].pos_q;

    // ----------------------------------------------------------------
    // Count-rate filter
    // ----------------------------------------------------------------
    logic filtIn;
    // A leaky integrator; its time constant of 2^FILT_SH cycles sets the
    // cutoff near 1.9 kHz, below 3 kHz, traded against a shift instead of a multiplier.
    assign filtIn = ctrl_q[pess_pkg::CTRL_FILT_B] && ctrl_q[6:4] < 3'h5 &&
        counted[ctrl_q[6:4]];

    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            filtY_q <= 24'h000000;
        end else begin
            filtY_q <= filtY_q - (filtY_q >> pess_pkg::FILT_SH) +
                (filtIn ? 24'h000100 : 24'h000000);
        end
    end

    assign filtOut = filtY_q[15:0];

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    levelStep_a: assert property (tick && phase_q == PESS_SCAN && level_q != 6'h3f
        |=> level_q == $past(level_q) + 6'h01)
        else $error("scan did not step up by one");
    levelHold_a: assert property (!tick |=> $stable(level_q))
        else $error("level changed between ticks");
    scanWrap_a: assert property (scanEnd && !dwellMode |=> level_q == 6'h00
        && phase_q == PESS_SCAN)
        else $error("scan did not restart at lowest level");
    dwellEnter_a: assert property (scanEnd && dwellMode |=> phase_q == PESS_DWELL
        && level_q == dwellLvl_q)
        else $error("dwell not entered after scan");
    dwellExit_a: assert property (dwellEnd |=> phase_q == PESS_SCAN && level_q == 6'h00)
        else $error("dwell did not return to scan");
    dwellWrap_a: assert property (dwellEnd && lastDwell |=> dwellIdx_q == 8'h00)
        else $error("program did not restart after last dwell");
    ewHold_a: assert property (ctrl_q[pess_pkg::CTRL_EWHOLD_B] |=> !stepPulse[1])
        else $error("east-west assembly moved while held");
    suppLevel_a: assert property (##1 suppNeg == ($past(level_q) >= SUPP_LEVEL))
        else $error("suppressor level wrong for step");
    apbAns_a: assert property (setupAcc |=> pready ##1 !pready)
        else $error("bus answer not one cycle");
    readLatch_a: assert property (tick |=> g_acc[0].rd_q == $past(g_acc[0].acc_q))
        else $error("reading not latched at tick");

    dwellSeen_c: cover property (scanEnd && dwellMode);
    gangSeen_c: cover property (gangOn && g_acc[5].inc);
    parkSeen_c: cover property (ctrl_q[pess_pkg::CTRL_PARK_B] && g_rot[0].pos_q == parkPos);

endmodule // pess_core

`default_nettype wire

// file: verilog/unused_placeholder_none.sv
// Empty design unit list holder.
`timescale 1ns/1ns
`default_nettype none
`default_nettype wire

// file: verif/pess_cmd_model.sv
// Command decoder model: ground commands and telemetry reads over APB.
`timescale 1ns/1ns
`default_nettype none

module pess_cmd_model (
    input wire logic clk,
    output logic psel,
    output logic penable,
    output logic pwrite,
    output logic [7:0] paddr,
    output logic [31:0] pwdata,
    input wire logic pready,
    input wire logic [31:0] prdata,
    input wire logic pslverr
);
    // --------------------------------------------------------------
    // Bus transfer
    // --------------------------------------------------------------
    // Idle bus at time zero.
    initial begin
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0000_0000;
    end

    // One transfer; pready, prdata and pslverr are read just after a rising
    // edge, so they are the values that edge sampled. Only the bench's
    // guard ends a wait that never sees pready.
    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                        output logic [31:0] r, output logic e);
        @(posedge clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        @(posedge clk);
        while (pready !== 1'b1) begin
            @(posedge clk);
        end
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
endmodule // pess_cmd_model

`default_nettype wire

// file: verif/pess_core_tb.sv
// Self-checking testbench of the energy step sequencer core.
`timescale 1ns/1ns
`default_nettype none

`define CHK(nm, ex, got) nTests++; if ((got) !== (ex)) begin failures++; \
    $display("ERROR %s expected %h seen %h", nm, ex, got); end

module pess_core_tb;
    localparam int TK = 60;
    logic core_clk, rstn, psel, penable, pwrite, pready, pslverr, suppNeg, hvHigh;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [4:0] detPulse;
    logic [5:0] energyLevel, lvl;
    logic [1:0] stepPulse, stepDir;
    logic [15:0] filtOut;
    logic er;
    int failures = 0, nTests = 0, cyc = 0, nsSteps = 0, ewSteps = 0, c, s0, k, j;
    typedef struct {logic [7:0] a; logic [31:0] d; logic e;} pess_row_s;
    pess_row_s rows[7];
    logic [5:0] dl[3];

    pess_core #(.TICK_CYC(TK), .STEP_CYC(20), .DEAD_CYC(4)) pess_core_inst (.core_clk(core_clk),
        .rstn(rstn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
        .detPulse(detPulse), .energyLevel(energyLevel), .suppNeg(suppNeg), .hvHigh(hvHigh),
        .stepPulse(stepPulse), .stepDir(stepDir), .filtOut(filtOut));
    pess_cmd_model pess_cmd_model_inst (.clk(core_clk), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata),
        .pslverr(pslverr));

    // --------------------------------------------------------------
    // Clock, step counters and hang guard
    // --------------------------------------------------------------
    // The guard sits well above the whole run, which lasts about four full scans.
    initial begin
        core_clk = 1'b0;
        forever #5 core_clk = ~core_clk;
    end
    always @(posedge core_clk) begin
        cyc++;
        nsSteps += stepPulse[0];
        ewSteps += stepPulse[1];
        if (cyc == 60000) begin
            failures++;
            report_and_stop();
        end
    end

    // --------------------------------------------------------------
    // Helpers
    // --------------------------------------------------------------
    task automatic report_and_stop();
        $display("Tests %0d failures %0d", nTests, failures);
        if (failures == 0 && nTests > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] r;
        logic e;
        pess_cmd_model_inst.xfer(1'b1, a, d, r, e);
    endtask
    // Waits for the level to move; the suppressor lags one cycle, so it
    // still shows the old level at the first settled point.
    task automatic nextStep(output int n);
        logic [5:0] old;
        old = energyLevel;
        n = 0;
        do begin
            @(negedge core_clk);
            n++;
        end while (energyLevel === old && n < 20000);
        `CHK("suppNeg", old >= 6'h20, suppNeg)
    endtask

    // --------------------------------------------------------------
    // Main sequence
    // --------------------------------------------------------------
    initial begin
        rstn = 1'b0;
        detPulse = 5'h00;
        rows = '{'{8'h00, pess_pkg::CTRL_RST, 0}, '{8'h04, pess_pkg::DWCFG_RST, 0},
                 '{8'h08, pess_pkg::DUR_RST, 0}, '{8'h0c, pess_pkg::LIM_RST, 0},
                 '{8'h10, pess_pkg::PARK_RST, 0}, '{8'h20, 32'h0, 0}, '{8'h40, 32'h0, 1}};
        dl = '{6'h3e, 6'h01, 6'h3e};
        repeat (2) @(posedge core_clk);
        `CHK("stepDir", 2'b11, stepDir)
        rstn <= 1'b1;
        // Register reset values and one unmapped place.
        foreach (rows[i]) begin
            pess_cmd_model_inst.xfer(1'b0, rows[i].a, 32'h0, rd, er);
            `CHK("regData", rows[i].d, rd)
            `CHK("regErr", rows[i].e, er)
        end
        // Step rate over the full range, then narrow limits, park and hold.
        @(negedge core_clk);
        s0 = nsSteps;
        repeat (200) @(negedge core_clk);
        `CHK("nsRate", 10, nsSteps - s0)
        wr(8'h0c, 32'h0001_4000);
        for (k = 0; k < 60; k++) begin
            pess_cmd_model_inst.xfer(1'b0, 8'h14, 32'h0, rd, er);
            `CHK("nsInLimit", 1'b1, rd[27:16] <= 12'h014)
        end
        wr(8'h10, 32'h0000_0004);
        wr(8'h00, 32'h0000_0804);
        repeat (2) @(negedge core_clk);
        s0 = ewSteps;
        repeat (400) @(posedge core_clk);
        pess_cmd_model_inst.xfer(1'b0, 8'h14, 32'h0, rd, er);
        `CHK("parkAngle", 12'd4, rd[27:16])
        `CHK("ewHeld", 0, ewSteps - s0)
        // Accumulators, dead time and filter on detector 0.
        // Second pulses come 3, 4 and 5 cycles after the first; only the
        // first of these falls inside the dead time.
        wr(8'h00, 32'h0000_080c);
        nextStep(c);
        @(posedge core_clk);
        for (k = 0; k < 3; k++) begin
            detPulse <= 5'h13;
            @(posedge core_clk);
            detPulse <= 5'h00;
            repeat (2 + k) @(posedge core_clk);
            detPulse <= {3'h0, k == 0, 1'b1};
            @(posedge core_clk);
            detPulse <= 5'h00;
            repeat (8) @(posedge core_clk);
        end
        `CHK("filtOut", 1'b1, filtOut != 16'h0)
        nextStep(c);
        for (k = 0; k < 6; k++) begin
            pess_cmd_model_inst.xfer(1'b0, 8'h20 + 8'(4 * k), 32'h0, rd, er);
            `CHK("accRead", (k == 0) ? 16'h0005 : (k == 2 || k == 3) ? 16'h0000 : 16'h0003, rd[15:0])
        end
        // Plain scan over a full wrap.
        nextStep(c);
        for (k = 0; k < 66; k++) begin
            lvl = energyLevel + 6'h01;
            nextStep(c);
            `CHK("scanLevel", lvl, energyLevel)
            `CHK("scanHold", TK, c)
        end
        // Scan-dwell: first 62, spacing 3 wraps to 1, two dwells of two ticks,
        // ganged to detector 0 so only accumulator 0 sees a sub-slot 0 pulse.
        wr(8'h04, 32'h0002_033e);
        wr(8'h08, 32'h0000_0002);
        wr(8'h00, 32'h0000_0887);
        @(negedge core_clk);
        `CHK("hvHigh", 1'b1, hvHigh)
        for (k = 0; k < 3; k++) begin
            j = 0;
            while (energyLevel !== 6'h3f && j < 70) begin
                nextStep(c);
                j++;
            end
            if (k > 0) begin
                `CHK("scanSteps", 63, j)
            end
            nextStep(c);
            `CHK("dwellLevel", dl[k], energyLevel)
            repeat (TK) @(posedge core_clk);
            detPulse <= 5'h03;
            @(posedge core_clk);
            detPulse <= 5'h00;
            `CHK("dwellMid", dl[k], energyLevel)
            nextStep(c);
            `CHK("dwellHold", TK, c)
            `CHK("afterDwell", 6'h00, energyLevel)
            for (j = 0; j < 6; j++) begin
                pess_cmd_model_inst.xfer(1'b0, 8'h20 + 8'(4 * j), 32'h0, rd, er);
                `CHK("gangAcc", (j == 0) ? 16'h0001 : 16'h0000, rd[15:0])
            end
        end
        report_and_stop();
    end
endmodule // pess_core_tb

`default_nettype wire
